// [bench/sfsp_front_chk.sv]
// Purpose: Port-level checker for the serial flash SPI front end
// Assumes: Pin inputs change well away from sys_clk_i edges
// Notes:   Pin windows cover synchroniser delay
module sfsp_front_chk (
    input wire        sys_clk_i,
    input wire        rst_n_i,
    input wire        spi_sck_i,
    input wire        spi_cs_n_i,
    input wire        spi_hold_n_i,
    input wire        bidir_data_line_oe_n_o,
    input wire        spi_so_o,
    input wire        spi_so_oe_n_o,
    input wire        standby_o,
    input wire [7:0]  status_o,
    input wire        rd_req_o,
    input wire        prog_strobe_o,
    input wire        prog_go_o,
    input wire        erase_go_o,
    input wire [1:0]  erase_kind_o,
    input wire        prot_err_o,
    input wire        array_busy_i
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_cs_idle;
        spi_cs_n_i [*8];
    endsequence
    sequence s_cs_active;
        !spi_cs_n_i [*8];
    endsequence
    // Enable edges are not data steps
    sequence s_so_step;
        !spi_so_oe_n_o && $past(!spi_so_oe_n_o) && $changed(spi_so_o) && !standby_o;
    endsequence

    idle_float_a: assert property (s_cs_idle |-> spi_so_oe_n_o && bidir_data_line_oe_n_o)
        else $error("Driven while deselected");
    standby_on_a: assert property (s_cs_idle |-> standby_o)
        else $error("Standby missing");
    select_wake_a: assert property (s_cs_active |-> !standby_o)
        else $error("Standby while selected");
    idle_quiet_a: assert property (standby_o |-> !rd_req_o && !prog_strobe_o)
        else $error("Activity while deselected");
    hold_float_a: assert property (!spi_hold_n_i [*8] |-> spi_so_oe_n_o && bidir_data_line_oe_n_o)
        else $error("Driven while paused");
    dual_pair_a: assert property (!bidir_data_line_oe_n_o |-> !spi_so_oe_n_o)
        else $error("Two-way line alone");
    busy_live_a: assert property (status_o[0] == array_busy_i && status_o[6:5] == 2'h0)
        else $error("Status bits wrong");
    write_enable_a: assert property (prog_strobe_o || erase_go_o |-> status_o[1])
        else $error("Write without latch");
    chip_clear_a: assert property (erase_go_o && erase_kind_o == 2'h3 |-> status_o[4:2] == 3'h0)
        else $error("Chip erase while protected");
    go_excl_a: assert property (prot_err_o |-> !prog_go_o && !erase_go_o ##1 !prot_err_o)
        else $error("Rejected write still started");
    so_on_fall_a: assert property (s_so_step |-> !spi_sck_i)
        else $error("Output moved off clock low");
    strobe_on_rise_a: assert property (prog_strobe_o |-> spi_sck_i && !spi_cs_n_i)
        else $error("Byte taken off rise");
endmodule

bind sfsp_front sfsp_front_chk i_sfsp_front_chk (.*);

// [bench/sfsp_spi_master.sv]
// Purpose: SPI master model driving the flash front end pins
// Assumes: Clock period of 48 ns made from 12 system cycles
// Notes:   Clock idles at cpol between frames
module sfsp_spi_master (
    input  wire  sys_clk_i,
    input  wire  so_i,
    input  wire  dline_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic hold_n_o,
    output logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cpol = 1'b0;

    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        hold_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic half;
        repeat (6) @(negedge sys_clk_i);
    endtask
    task automatic sel;
        @(negedge sys_clk_i);
        sck_o = cpol;
        half();
        cs_n_o = 1'b0;
        half();
    endtask
    task automatic desel;
        half();
        sck_o = cpol;
        half();
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        half();
    endtask
    // Sample just before each rise
    task automatic xbyte(input logic [7:0] tx, input bit dual, output logic [7:0] rx);
        int i;
        for (i = 0; i < (dual ? 4 : 8); i++) begin
            sck_o = 1'b0;
            mosi_o = dual ? ~mosi_o : tx[7 - i];
            half();
            rx = dual ? {rx[5:0], so_i, dline_i} : {rx[6:0], so_i};
            sck_o = 1'b1;
            half();
        end
    endtask
    // Pause with the clock low
    task automatic hold(input bit on);
        if (on) begin
            sck_o = 1'b0;
            half();
        end
        hold_n_o = ~on;
        half();
        half();
    endtask
endmodule

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the serial flash SPI front end
// Assumes: Array data is address low byte xor 5a, one cycle after request
// Notes:   Busy lasts 20 cycles after each commit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i;
    logic        rst_n_i;
    logic        spi_wp_n_i;
    logic [7:0]  rd_data_i = 8'h00;
    wire         array_busy_i, spi_sck_i, spi_cs_n_i, spi_hold_n_i, mosi, bidir_data_line_i;
    wire         bidir_data_line_o, bidir_data_line_oe_n_o, spi_so_o, spi_so_oe_n_o, standby_o;
    wire         rd_req_o, prog_strobe_o, prog_go_o, erase_go_o, prot_err_o;
    wire [7:0]   status_o, prog_data_o;
    wire [18:0]  rd_addr_o, prog_addr_o, erase_addr_o;
    wire [1:0]   erase_kind_o;
    logic [7:0]  rx, opc, last_pd;
    logic [18:0] a, last_pa, last_ea;
    logic [1:0]  last_kind;
    int          bad_count, comparisons, n_strobe, n_go, n_err, busy_cnt, m;

    assign bidir_data_line_i = bidir_data_line_oe_n_o ? mosi : bidir_data_line_o;
    assign array_busy_i = busy_cnt != 0;

    sfsp_front i_sfsp_front (.*);
    sfsp_spi_master i_master (.sys_clk_i(sys_clk_i), .so_i(spi_so_o ^ spi_so_oe_n_o), .dline_i(bidir_data_line_i),
        .sck_o(spi_sck_i), .cs_n_o(spi_cs_n_i), .hold_n_o(spi_hold_n_i), .mosi_o(mosi));

    // Data toggles off its valid cycle
    always @(posedge sys_clk_i) begin
        rd_data_i <= rd_req_o ? (rd_addr_o[7:0] ^ 8'h5a) : ~rd_data_i;
        busy_cnt <= (prog_go_o || erase_go_o) ? 20 : ((busy_cnt > 0) ? busy_cnt - 1 : 0);
        if (prog_strobe_o) begin
            n_strobe++;
            last_pd <= prog_data_o;
            last_pa <= prog_addr_o;
        end
        if (prog_go_o || erase_go_o)
            n_go++;
        if (erase_go_o) begin
            last_kind <= erase_kind_o;
            last_ea <= erase_addr_o;
        end
        if (prot_err_o)
            n_err++;
    end

    task automatic complete_run;
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic op(input logic [7:0] code, input logic [18:0] adr, input bit with_adr);
        i_master.sel();
        i_master.xbyte(code, 1'b0, rx);
        if (with_adr)
            for (int k = 16; k >= 0; k -= 8)
                i_master.xbyte(8'(adr >> k), 1'b0, rx);
    endtask
    task automatic finish_cmd;
        i_master.desel();
        repeat (10) @(negedge sys_clk_i);
    endtask
    task automatic set_latch;
        op(8'h06, 19'h00000, 1'b0);
        finish_cmd();
    endtask
    task automatic put_status(input logic [7:0] v);
        set_latch();
        op(8'h01, 19'h00000, 1'b0);
        i_master.xbyte(v, 1'b0, rx);
        finish_cmd();
    endtask
    task automatic wait_idle;
        int k;
        for (k = 0; k < 100 && array_busy_i; k++)
            @(negedge sys_clk_i);
        if (array_busy_i) begin
            bad_count++;
            complete_run();
        end
        repeat (2) @(negedge sys_clk_i);
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        bad_count++;
        complete_run();
    end
    initial begin
        rst_n_i = 1'b0;
        spi_wp_n_i = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        check(status_o, 8'h00, "reset status");
        check({standby_o, spi_so_oe_n_o, bidir_data_line_oe_n_o}, 3'h7, "idle pins");
        i_master.xbyte(8'h06, 1'b0, rx);
        i_master.desel();
        check(status_o, 8'h00, "deselected cmd");
        set_latch();
        check(status_o, 8'h02, "enable latch");
        op(8'h05, 19'h00000, 1'b0);
        i_master.xbyte(8'h00, 1'b0, rx);
        check(rx, 8'h02, "status read");
        finish_cmd();
        op(8'h04, 19'h00000, 1'b0);
        finish_cmd();
        check(status_o, 8'h00, "latch off");
        a = 19'h7fffe;
        for (m = 0; m < 4; m++) begin
            i_master.cpol = m[0];
            opc = (m < 2) ? 8'h03 : ((m == 2) ? 8'h0b : 8'h3b);
            op(opc, a, 1'b1);
            if (m > 1)
                i_master.xbyte(8'h00, 1'b0, rx);
            i_master.xbyte(8'h00, m == 3, rx);
            check(rx, a[7:0] ^ 8'h5a, "read byte 1");
            i_master.hold(1'b1);
            check({spi_so_oe_n_o, bidir_data_line_oe_n_o}, 2'h3, "paused pins");
            i_master.hold(1'b0);
            i_master.xbyte(8'h00, m == 3, rx);
            check(rx, (a[7:0] + 8'h01) ^ 8'h5a, "read byte 2");
            finish_cmd();
        end
        i_master.cpol = 1'b0;
        set_latch();
        op(8'h02, 19'h100fe, 1'b1);
        for (m = 0; m < 4; m++)
            i_master.xbyte(8'h3c + m[7:0], 1'b0, rx);
        finish_cmd();
        check(n_strobe, 4, "program bytes");
        check({last_pa, last_pd}, {19'h10001, 8'h3f}, "last byte");
        check(n_go, 1, "program commit");
        wait_idle();
        check(status_o, 8'h00, "latch cleared");
        put_status(8'h9c);
        check(status_o, 8'h9c, "status set");
        put_status(8'h00);
        check(status_o, 8'h9e, "locked status");
        for (m = 0; m < 2; m++) begin
            set_latch();
            op(m ? 8'hc7 : 8'hd7, 19'h12345, m == 0);
            finish_cmd();
        end
        check({n_err[7:0], n_go[7:0]}, 16'h0201, "protected erases");
        spi_wp_n_i = 1'b1;
        set_latch();
        op(8'hd8, 19'h3abcd, 1'b1);
        finish_cmd();
        check(n_go, 2, "erase unprotected");
        check({last_kind, last_ea}, {2'h2, 19'h30000}, "block erase");
        wait_idle();
        put_status(8'h00);
        check(status_o, 8'h00, "unlocked status");
        spi_wp_n_i = 1'b0;
        for (m = 0; m < 3; m++) begin
            opc = (m == 0) ? 8'hd7 : ((m == 1) ? 8'hd8 : 8'hc7);
            set_latch();
            op(opc, 19'h5abcd, m < 2);
            finish_cmd();
            check(last_kind, m + 1, "erase kind");
            if (m < 2)
                check(last_ea, m ? 19'h50000 : 19'h5a000, "erase base");
            wait_idle();
        end
        check({n_err[7:0], n_go[7:0]}, 16'h0205, "erase totals");
        complete_run();
    end
endmodule

// [core/sfsp_front.v]
// Purpose: SPI slave front end of a 4 Mbit serial flash
// Assumes: sck below a tenth of sys_clk
// Notes:   Array read data must arrive one cycle after rd_req_o
`include "sfsp_map.vh"
// Summary of operation
// - Chip select low wakes the front end for a transaction.
// - Chip select high deselects and reports standby.
// - Data input is ignored while deselected.
// - Data outputs float while deselected.
// - Write-protect low: protect bits decide which area is read-only.
// - Write-protect high: no program or sector/block erase protection; chip erase still needs protect bits zero.
// - Pause input freezes the transaction without losing received bits.
// - Only modes 0 and 3; master idles clock low or high.
// - Incoming bits are sampled on rising clock edges.
// - Outgoing bits change on falling clock edges.
// - Dual fast read drives two bits per clock on both lines.
// - Page program writes one to 256 bytes.
// - Array splits into 4 KByte sectors and 64 KByte blocks.
// - Eight blocks, 512K byte locations.
// - Protect bits make part or all of array read-only.
// - Erase by sector, block or whole chip.
// - Write-enable latch set by command, cleared when write completes.
// - Status: busy bit 0, latch bit 1, protect bits 2-4, lock bit 7.
// - Lock set with write-protect low ignores status writes.
// - Chip erase runs only when all protect bits are zero.
module sfsp_front (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    input  wire        spi_sck_i,
    input  wire        spi_cs_n_i,
    input  wire        spi_hold_n_i,
    input  wire        spi_wp_n_i,
    input  wire        bidir_data_line_i,
    output reg         bidir_data_line_o,
    output wire        bidir_data_line_oe_n_o,
    output reg         spi_so_o,
    output wire        spi_so_oe_n_o,
    output wire        standby_o,
    output wire [7:0]  status_o,
    output reg         rd_req_o,
    output reg  [18:0] rd_addr_o,
    input  wire [7:0]  rd_data_i,
    output reg         prog_strobe_o,
    output reg  [18:0] prog_addr_o,
    output reg  [7:0]  prog_data_o,
    output reg         prog_go_o,
    output reg         erase_go_o,
    output reg  [1:0]  erase_kind_o,
    output reg  [18:0] erase_addr_o,
    output reg         prot_err_o,
    input  wire        array_busy_i
);
    localparam ST_OPC  = 6'b000001;
    localparam ST_ADR  = 6'b000010;
    localparam ST_DUM  = 6'b000100;
    localparam ST_RX   = 6'b001000;
    localparam ST_TX   = 6'b010000;
    localparam ST_SKIP = 6'b100000;

    wire        sck_s;
    wire        cs_n_s;
    wire        hold_n_s;
    wire        wp_n_s;
    wire        din_s;

    reg         sck_p_q;
    reg         cs_p_q;
    reg         busy_p_q;
    reg  [5:0]  st_q;
    reg  [7:0]  cmd_q;
    reg  [7:0]  sh_q;
    reg  [2:0]  bcnt_q;
    reg  [5:0]  tot_q;
    reg  [23:0] addr_q;
    reg  [18:0] raddr_q;
    reg  [8:0]  nb_q;
    reg         pp_ok_q;
    reg  [7:0]  wsr_q;
    reg         wel_q;
    reg  [2:0]  bp_q;
    reg         lock_q;
    reg  [7:0]  nbyte_q;
    reg  [7:0]  tsh_q;
    reg  [2:0]  ocnt_q;
    reg         rd_vld_q;
    reg         drv_q;

    wire        act      = ~cs_n_s & hold_n_s;
    wire        rise     = act & sck_s & ~sck_p_q;
    wire        fall     = act & ~sck_s & sck_p_q;
    wire        cs_rise  = cs_n_s & ~cs_p_q;
    wire        busy     = array_busy_i;
    wire        is_dual  = (cmd_q == `SFSP_OP_DUAL);
    wire        is_rdsr  = (cmd_q == `SFSP_OP_RDSR);
    wire [7:0]  byte_in  = {sh_q[6:0], din_s};
    wire        byte_end = (bcnt_q == 3'h7);
    wire [2:0]  olast    = is_dual ? 3'h3 : 3'h7;
    wire [23:0] addr_in  = {addr_q[22:0], din_s};
    wire        wsr_ok   = wel_q & ~busy & ~(lock_q & ~wp_n_s);

    assign status_o = {lock_q, 2'b00, bp_q, wel_q, busy};
    assign standby_o = cs_n_s;
    // Float unless selected, running and reading
    assign spi_so_oe_n_o = ~(act & drv_q);
    assign bidir_data_line_oe_n_o = ~(act & drv_q & is_dual);

    sfsp_sync #(.RST_VAL(1'b0)) u_sck (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .din_i     (spi_sck_i),
        .q_o       (sck_s)
    );
    sfsp_sync #(.RST_VAL(1'b1)) u_cs (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .din_i     (spi_cs_n_i),
        .q_o       (cs_n_s)
    );
    sfsp_sync #(.RST_VAL(1'b1)) u_hold (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .din_i     (spi_hold_n_i),
        .q_o       (hold_n_s)
    );
    sfsp_sync #(.RST_VAL(1'b1)) u_wp (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .din_i     (spi_wp_n_i),
        .q_o       (wp_n_s)
    );
    sfsp_sync #(.RST_VAL(1'b0)) u_din (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .din_i     (bidir_data_line_i),
        .q_o       (din_s)
    );

    // Top blocks protected; area doubles per code step from 1 to 4, codes 4 to 7 protect all
    function prot_f;
        input [18:0] a;
        input [2:0]  bp;
        input        wpn;
        reg   [3:0]  first;
        begin
            first = 4'h0;
            if (bp == 3'h0 || bp == 3'h7 || bp >= 3'h4) begin
                first = (bp == 3'h0) ? `SFSP_NUM_BLKS : 4'h0;
            end else begin
                first = `SFSP_NUM_BLKS - (4'h1 << (bp - 3'h1));
            end
            // Block index from top address bits
            prot_f = wpn ? 1'b0 : ({1'b0, a[18:`SFSP_BLK_LSB]} >= first);
        end
    endfunction

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_p_q  <= 1'b0;
            cs_p_q   <= 1'b1;
            busy_p_q <= 1'b0;
        end else begin
            // Edges during a pause are lost, state kept
            sck_p_q  <= sck_s;
            cs_p_q   <= cs_n_s;
            busy_p_q <= busy;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q          <= ST_OPC;
            cmd_q         <= 8'h00;
            sh_q          <= 8'h00;
            bcnt_q        <= 3'h0;
            tot_q         <= 6'h00;
            addr_q        <= 24'h000000;
            raddr_q       <= 19'h00000;
            nb_q          <= 9'h000;
            pp_ok_q       <= 1'b0;
            wsr_q         <= 8'h00;
            rd_req_o      <= 1'b0;
            rd_addr_o     <= 19'h00000;
            prog_strobe_o <= 1'b0;
            prog_addr_o   <= 19'h00000;
            prog_data_o   <= 8'h00;
        end else begin
            rd_req_o      <= 1'b0;
            prog_strobe_o <= 1'b0;
            if (cs_n_s) begin
                // Deselected: pin data never enters the shifter
                st_q   <= ST_OPC;
                bcnt_q <= 3'h0;
                tot_q  <= 6'h00;
                nb_q   <= 9'h000;
            end else if (rise) begin
                sh_q   <= byte_in;
                bcnt_q <= bcnt_q + 3'h1;
                if (tot_q != `SFSP_BITS_SAT) begin
                    tot_q <= tot_q + 6'h01;
                end
                case (st_q)
                    ST_OPC: begin
                        if (byte_end) begin
                            cmd_q <= byte_in;
                            case (byte_in)
                                `SFSP_OP_READ, `SFSP_OP_FAST, `SFSP_OP_DUAL,
                                `SFSP_OP_PROG, `SFSP_OP_SEC_ER, `SFSP_OP_BLK_ER: begin
                                    st_q <= ST_ADR;
                                end
                                `SFSP_OP_STATUS_WRITE_CMD: begin
                                    st_q <= ST_RX;
                                end
                                `SFSP_OP_RDSR: begin
                                    st_q <= ST_TX;
                                end
                                default: begin
                                    st_q <= ST_SKIP;
                                end
                            endcase
                        end
                    end
                    ST_ADR: begin
                        addr_q <= addr_in;
                        if (tot_q == `SFSP_BITS_ADR - 6'h01) begin
                            raddr_q <= addr_in[18:0];
                            pp_ok_q <= wel_q & ~busy & ~prot_f(addr_in[18:0], bp_q, wp_n_s);
                            case (cmd_q)
                                `SFSP_OP_READ: begin
                                    st_q      <= ST_TX;
                                    rd_req_o  <= 1'b1;
                                    rd_addr_o <= addr_in[18:0];
                                    raddr_q   <= addr_in[18:0] + 19'h00001;
                                end
                                `SFSP_OP_FAST, `SFSP_OP_DUAL: begin
                                    st_q      <= ST_DUM;
                                    rd_req_o  <= 1'b1;
                                    rd_addr_o <= addr_in[18:0];
                                    raddr_q   <= addr_in[18:0] + 19'h00001;
                                end
                                `SFSP_OP_PROG: begin
                                    st_q <= ST_RX;
                                end
                                default: begin
                                    st_q <= ST_SKIP;
                                end
                            endcase
                        end
                    end
                    ST_DUM: begin
                        if (byte_end) begin
                            st_q <= ST_TX;
                        end
                    end
                    ST_RX: begin
                        if (byte_end) begin
                            if (cmd_q == `SFSP_OP_STATUS_WRITE_CMD) begin
                                wsr_q <= byte_in;
                                st_q  <= ST_SKIP;
                            end else if (nb_q != `SFSP_PAGE_BYTES) begin
                                // Bytes past a full page are dropped
                                nb_q <= nb_q + 9'h001;
                                if (pp_ok_q) begin
                                    prog_strobe_o <= 1'b1;
                                    prog_data_o   <= byte_in;
                                    // Column wraps inside the page
                                    prog_addr_o   <= {raddr_q[18:8], raddr_q[7:0] + nb_q[7:0]};
                                end
                            end
                        end
                    end
                    ST_TX: begin
                    end
                    ST_SKIP: begin
                    end
                    default: begin
                        st_q <= ST_SKIP;
                    end
                endcase
            end else if (fall && st_q == ST_TX && ocnt_q == 3'h0 && !is_rdsr) begin
                // Prefetch while this byte shifts out
                rd_req_o  <= 1'b1;
                rd_addr_o <= raddr_q;
                raddr_q   <= raddr_q + 19'h00001;
            end
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_vld_q          <= 1'b0;
            nbyte_q           <= 8'h00;
            tsh_q             <= 8'h00;
            ocnt_q            <= 3'h0;
            drv_q             <= 1'b0;
            spi_so_o          <= 1'b0;
            bidir_data_line_o <= 1'b0;
        end else begin
            rd_vld_q <= rd_req_o;
            if (is_rdsr) begin
                nbyte_q <= status_o;
            end else if (rd_vld_q) begin
                nbyte_q <= rd_data_i;
            end
            if (cs_n_s) begin
                ocnt_q <= 3'h0;
                drv_q  <= 1'b0;
            end else if (fall && st_q == ST_TX) begin
                drv_q  <= 1'b1;
                ocnt_q <= (ocnt_q == olast) ? 3'h0 : ocnt_q + 3'h1;
                if (ocnt_q == 3'h0) begin
                    spi_so_o          <= nbyte_q[7];
                    bidir_data_line_o <= nbyte_q[6];
                    tsh_q             <= is_dual ? {nbyte_q[5:0], 2'b00} : {nbyte_q[6:0], 1'b0};
                end else begin
                    spi_so_o          <= tsh_q[7];
                    bidir_data_line_o <= tsh_q[6];
                    // Dual: two bits per fall
                    tsh_q <= is_dual ? {tsh_q[5:0], 2'b00} : {tsh_q[6:0], 1'b0};
                end
            end
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wel_q        <= |(`SFSP_SR_RST & (8'h01 << `SFSP_SR_WEL));
            bp_q         <= 3'h0;
            lock_q       <= 1'b0;
            prog_go_o    <= 1'b0;
            erase_go_o   <= 1'b0;
            erase_kind_o <= 2'h0;
            erase_addr_o <= 19'h00000;
            prot_err_o   <= 1'b0;
        end else begin
            prog_go_o  <= 1'b0;
            erase_go_o <= 1'b0;
            prot_err_o <= 1'b0;
            if (busy_p_q && !busy) begin
                wel_q <= 1'b0;
            end
            if (cs_rise && !busy) begin
                case (cmd_q)
                    `SFSP_OP_SET_WRITE_ENABLE_CMD: begin
                        if (tot_q == `SFSP_BITS_OPC) begin
                            wel_q <= 1'b1;
                        end
                    end
                    `SFSP_OP_WRDI: begin
                        if (tot_q == `SFSP_BITS_OPC) begin
                            wel_q <= 1'b0;
                        end
                    end
                    `SFSP_OP_STATUS_WRITE_CMD: begin
                        if (tot_q == `SFSP_BITS_STATUS_WRITE_CMD && wsr_ok) begin
                            lock_q <= wsr_q[`SFSP_SR_LOCK];
                            bp_q   <= wsr_q[`SFSP_SR_BP_MSB:`SFSP_SR_BP_LSB];
                            wel_q  <= 1'b0;
                        end
                    end
                    `SFSP_OP_PROG: begin
                        if (nb_q != 9'h000 && bcnt_q == 3'h0 && wel_q) begin
                            prog_go_o  <= pp_ok_q;
                            prot_err_o <= ~pp_ok_q;
                        end
                    end
                    `SFSP_OP_SEC_ER, `SFSP_OP_BLK_ER: begin
                        if (tot_q == `SFSP_BITS_ADR && wel_q) begin
                            if (prot_f(addr_q[18:0], bp_q, wp_n_s)) begin
                                prot_err_o <= 1'b1;
                            end else begin
                                erase_go_o <= 1'b1;
                                if (cmd_q == `SFSP_OP_SEC_ER) begin
                                    erase_kind_o <= `SFSP_ER_SEC;
                                    erase_addr_o <= {addr_q[18:`SFSP_SEC_LSB], 12'h000};
                                end else begin
                                    erase_kind_o <= `SFSP_ER_BLK;
                                    erase_addr_o <= {addr_q[18:`SFSP_BLK_LSB], 16'h0000};
                                end
                            end
                        end
                    end
                    `SFSP_OP_FULL_ERASE_CMD: begin
                        if (tot_q == `SFSP_BITS_OPC && wel_q) begin
                            if (bp_q == 3'h0) begin
                                erase_go_o   <= 1'b1;
                                erase_kind_o <= `SFSP_ER_CHIP;
                                erase_addr_o <= 19'h00000;
                            end else begin
                                prot_err_o <= 1'b1;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule

// [core/sfsp_map.vh]
// Purpose: Constants for the serial flash SPI front end
// Assumes: Included by every sfsp design file
// Notes:   Opcode values are arbitrary house codes
`ifndef SFSP_MAP_VH
`define SFSP_MAP_VH

`define SFSP_ADDR_W      19
`define SFSP_ADDR_MAX    19'h7ffff
`define SFSP_PAGE_BYTES  9'h100
`define SFSP_BLK_LSB     16
`define SFSP_SEC_LSB     12
`define SFSP_NUM_BLKS    4'h8

`define SFSP_OP_SET_WRITE_ENABLE_CMD     8'h06
`define SFSP_OP_WRDI     8'h04
`define SFSP_OP_RDSR     8'h05
`define SFSP_OP_STATUS_WRITE_CMD     8'h01
`define SFSP_OP_READ     8'h03
`define SFSP_OP_FAST     8'h0b
`define SFSP_OP_DUAL     8'h3b
`define SFSP_OP_PROG     8'h02
`define SFSP_OP_SEC_ER   8'hd7
`define SFSP_OP_BLK_ER   8'hd8
`define SFSP_OP_FULL_ERASE_CMD  8'hc7

`define SFSP_SR_BUSY     0
`define SFSP_SR_WEL      1
`define SFSP_SR_BP_LSB   2
`define SFSP_SR_BP_MSB   4
`define SFSP_SR_LOCK     7
`define SFSP_SR_RST      8'h00

`define SFSP_BITS_OPC    6'h08
`define SFSP_BITS_STATUS_WRITE_CMD   6'h10
`define SFSP_BITS_ADR    6'h20
`define SFSP_BITS_SAT    6'h3f

`define SFSP_ER_SEC      2'h1
`define SFSP_ER_BLK      2'h2
`define SFSP_ER_CHIP     2'h3

`endif

// [core/sfsp_sync.v]
// Purpose: Three-flop synchroniser for one pin input
// Assumes: Input is asynchronous to sys_clk_i
// Notes:   Output moves only when stages two and three agree
`include "sfsp_map.vh"
module sfsp_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire sys_clk_i,
    input  wire rst_n_i,
    input  wire din_i,
    output reg  q_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            s1_q <= din_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_o <= s3_q;
            end
        end
    end
endmodule
